// *** design/sacc_top.v ***
// Functional notes
// - 10-bit result; high read gives top eight
// - low read puts two LSBs high
// - conversion DAC code is result register
// - done flag; skip or interrupt handling
// - flag clears on interrupt or skip
// - start op converts, result stored automatically
// - result cleared at conversion start
// - MSB-first trials, keep if reference below
// - conversion ends after 62 machine cycles
// - control bit 3 one selects comparator
// - 8-bit reference loaded from B and A
// - reference kept across mode switches
// - reference accessed only in comparator mode
// - comparator DAC code is reference register
// - flag set when input below reference
// - comparison ends after 8 machine cycles
// - skip after mode change clears stray flag
// - bit 3 zero converts; reset all zeros
// - low bits select four inputs or none
`timescale 1ns/1ps
`include "sacc_defines.vh"
module sacc_top #(
   parameter MCYCLE_DIV = 2,
   parameter CONV_CYCLES = `SACC_CONV_CYCLES,
   parameter CMP_CYCLES = `SACC_CMP_CYCLES,
   parameter BIT_CYCLES = `SACC_BIT_CYCLES
)(
   // clock and reset
   input wire clk_in,
   input wire rstn_in,
   // cpu instruction strobes, one clock each
   input wire conv_start_op_in,
   input wire read_result_high_op_in,
   input wire read_result_low_op_in,
   input wire load_compare_ref_op_in,
   input wire read_compare_ref_op_in,
   input wire skip_if_done_op_in,
   input wire write_control_op_in,
   input wire irq_ack_in,
   // cpu working registers
   input wire [3:0] reg_a_in,
   input wire [3:0] reg_b_in,
   // interrupt select bit of the second interrupt control register
   input wire irq_enable_in,
   // analog side: comparator says dac reference below input
   input wire cmp_ref_below_in,
   // cpu results
   output reg [3:0] data_a_out,
   output reg [3:0] data_b_out,
   output reg data_valid_out,
   output reg skip_out,
   output reg [`SACC_CTRL_W-1:0] converter_control_reg_out,
   // converter status
   output reg conv_done_flag_out,
   output reg irq_req_out,
   output reg busy_out,
   // analog side
   output reg [`SACC_RES_W-1:0] dac_code_out,
   output reg [3:0] input_select_out
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_CONV = 3'b010;
   localparam [2:0] ST_CMP = 3'b100;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [`SACC_CTRL_W-1:0] ctrl_reg;
   reg [`SACC_RES_W-1:0] result_reg;
   reg [`SACC_RES_W-1:0] result_next;
   reg [`SACC_REF_W-1:0] ref_reg;
   reg [6:0] mcount_reg;
   reg [6:0] mcount_next;
   reg [3:0] bit_reg;
   reg [3:0] bit_next;
   reg flag_set;
   reg flag_value;
   reg op_done;
   wire mtick;
   wire cmp_below_sync;
   wire cmp_mode;
   wire flag_clear;
   wire [6:0] conv_last;
   wire [6:0] cmp_last;
   wire [6:0] bit_last;
   assign cmp_mode = ctrl_reg[`SACC_MODE_BIT];
   assign conv_last = CONV_CYCLES[6:0] - 7'h01;
   assign cmp_last = CMP_CYCLES[6:0] - 7'h01;
   assign bit_last = BIT_CYCLES[6:0] - 7'h01;
   // flag is cleared by the taken interrupt or a skip that hits it
   assign flag_clear = (irq_ack_in & irq_enable_in) |
      (skip_if_done_op_in & ~irq_enable_in & conv_done_flag_out);

   sacc_mcycle_div #(
      .DIV(MCYCLE_DIV)
   ) u_div (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .tick_out(mtick)
   );

   // comparator output is asynchronous to the clock
   sacc_sync2 u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in(cmp_ref_below_in),
      .q_out(cmp_below_sync)
   );

   // sequencer: machine-cycle counter paces bit trials and the end point
   always @*
   begin
      state_next = state_reg;
      result_next = result_reg;
      mcount_next = mcount_reg;
      bit_next = bit_reg;
      flag_set = 1'b0;
      flag_value = 1'b0;
      op_done = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            if (conv_start_op_in)
            begin
               mcount_next = 7'h00;
               if (cmp_mode)
               begin
                  state_next = ST_CMP;
               end
               else
               begin
                  state_next = ST_CONV;
                  // clear then set the msb trial
                  result_next = `SACC_RES_CLEAR;
                  result_next[`SACC_RES_W-1] = 1'b1;
                  bit_next = 4'h9;
               end
            end
         end
         ST_CONV:
         begin
            if (mtick)
            begin
               mcount_next = mcount_reg + 7'h01;
               // decide a trial at the end of each bit slot
               if (bit_reg != 4'hF && mcount_reg == (bit_last + 
                  (BIT_CYCLES[6:0] * (7'h09 - {3'h0, bit_reg}))))
               begin
                  // keep the bit only if reference below input
                  result_next[bit_reg] = cmp_below_sync;
                  if (bit_reg != 4'h0)
                  begin
                     result_next[bit_reg - 4'h1] = 1'b1;
                  end
                  bit_next = bit_reg - 4'h1;
               end
               if (mcount_reg == conv_last)
               begin
                  state_next = ST_IDLE;
                  flag_set = 1'b1;
                  flag_value = 1'b1;
                  op_done = 1'b1;
               end
            end
         end
         ST_CMP:
         begin
            if (mtick)
            begin
               mcount_next = mcount_reg + 7'h01;
               if (mcount_reg == cmp_last)
               begin
                  state_next = ST_IDLE;
                  // input below reference means reference not below input
                  flag_set = 1'b1;
                  flag_value = ~cmp_below_sync;
                  op_done = 1'b1;
               end
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // state, counters and result register
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         state_reg <= ST_IDLE;
         result_reg <= `SACC_RES_CLEAR;
         mcount_reg <= 7'h00;
         bit_reg <= 4'hF;
         busy_out <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         result_reg <= result_next;
         mcount_reg <= mcount_next;
         bit_reg <= bit_next;
         busy_out <= (state_next != ST_IDLE);
      end
   end

   // control register; reference only writable in comparator mode
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         ctrl_reg <= `SACC_CTRL_RESET;
         ref_reg <= 8'h00;
      end
      else
      begin
         if (write_control_op_in)
         begin
            ctrl_reg <= reg_a_in;
         end
         // reference survives mode changes, never cleared by them
         if (load_compare_ref_op_in && cmp_mode)
         begin
            ref_reg <= {reg_b_in, reg_a_in};
         end
      end
   end

   // control mirror written on the same edge, so the pin never lags the mode
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         converter_control_reg_out <= `SACC_CTRL_RESET;
      end
      else if (write_control_op_in)
      begin
         converter_control_reg_out <= reg_a_in;
      end
   end

   // done flag: a completing operation wins over a same-cycle clear
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         conv_done_flag_out <= 1'b0;
      end
      else
      begin
         if (flag_set)
         begin
            conv_done_flag_out <= flag_value;
         end
         else if (flag_clear)
         begin
            conv_done_flag_out <= 1'b0;
         end
      end
   end

   // request pulse at completion when the flag sets, routed only in interrupt mode
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         irq_req_out <= 1'b0;
      end
      else
      begin
         irq_req_out <= op_done & irq_enable_in & (flag_value | ~cmp_mode);
      end
   end

   // cpu read paths; low read forces accumulator low bits to zero
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         data_a_out <= 4'h0;
         data_b_out <= 4'h0;
         data_valid_out <= 1'b0;
         skip_out <= 1'b0;
      end
      else
      begin
         data_valid_out <= 1'b0;
         skip_out <= skip_if_done_op_in & conv_done_flag_out & ~irq_enable_in;
         if (read_result_high_op_in)
         begin
            data_b_out <= result_reg[9:6];
            data_a_out <= result_reg[5:2];
            data_valid_out <= 1'b1;
         end
         else if (read_result_low_op_in)
         begin
            data_a_out <= {result_reg[1:0], 2'b00};
            data_valid_out <= 1'b1;
         end
         else if (read_compare_ref_op_in && cmp_mode)
         begin
            data_b_out <= ref_reg[7:4];
            data_a_out <= ref_reg[3:0];
            data_valid_out <= 1'b1;
         end
      end
   end

   // dac code: result in conversion mode, reference scaled in comparator mode
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         dac_code_out <= `SACC_RES_CLEAR;
         input_select_out <= 4'h0;
      end
      else
      begin
         if (cmp_mode)
         begin
            dac_code_out <= {ref_reg, 2'b00};
         end
         else
         begin
            dac_code_out <= result_next;
         end
         // one-hot input enables; other codes select nothing
         case (ctrl_reg[`SACC_SEL_MSB:0])
            `SACC_SEL_IN0: input_select_out <= 4'h1;
            `SACC_SEL_IN1: input_select_out <= 4'h2;
            `SACC_SEL_IN4: input_select_out <= 4'h4;
            `SACC_SEL_IN5: input_select_out <= 4'h8;
            default: input_select_out <= 4'h0;
         endcase
      end
   end
endmodule

// *** shared/sacc_defines.vh ***
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH
// converter control register fields and reset value
`define SACC_CTRL_W 4
`define SACC_CTRL_RESET 4'h0
`define SACC_MODE_BIT 3
`define SACC_SEL_MSB 2
// analog input select codes
`define SACC_SEL_IN0 3'h0
`define SACC_SEL_IN1 3'h1
`define SACC_SEL_IN4 3'h4
`define SACC_SEL_IN5 3'h5
// result and reference widths
`define SACC_RES_W 10
`define SACC_REF_W 8
`define SACC_RES_CLEAR 10'h000
// operation lengths in machine cycles
`define SACC_CONV_CYCLES 62
`define SACC_CMP_CYCLES 8
// machine cycles spent on each bit trial of a conversion
`define SACC_BIT_CYCLES 6
`endif

// *** design/sacc_mcycle_div.v ***
`timescale 1ns/1ps
// machine cycle enable divider
module sacc_mcycle_div #(
   parameter DIV = 1
)(
   // clock and reset
   input wire clk_in,
   input wire rstn_in,
   // enable out
   output reg tick_out
);
   reg [15:0] cnt_reg;
   // one-cycle enable every DIV clocks
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         cnt_reg <= 16'h0000;
         tick_out <= 1'b0;
      end
      else if (cnt_reg == DIV[15:0] - 16'h0001)
      begin
         cnt_reg <= 16'h0000;
         tick_out <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 16'h0001;
         tick_out <= 1'b0;
      end
   end
endmodule

// *** design/sacc_sync2.v ***
`timescale 1ns/1ps
// two flip-flop synchroniser for the comparator level
module sacc_sync2 (
   // clock and reset
   input wire clk_in,
   input wire rstn_in,
   // level
   input wire d_in,
   output reg q_out
);
   reg meta_reg;
   // the first stage is read only by the second
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         meta_reg <= 1'b0;
         q_out <= 1'b0;
      end
      else
      begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule

// *** tb/sacc_chk.sv ***
`timescale 1ns/1ps
// port checker, sees only the converter's top-level pins
module sacc_chk #(
   parameter MCYCLE_DIV = 2,
   parameter CONV_CYCLES = 62
)(
   input wire clk_in, rstn_in, conv_start_op_in, read_result_high_op_in,
   input wire read_result_low_op_in, load_compare_ref_op_in, read_compare_ref_op_in,
   input wire skip_if_done_op_in, irq_enable_in, data_valid_out, skip_out,
   input wire [3:0] reg_a_in, reg_b_in, data_a_out, data_b_out, converter_control_reg_out,
   input wire conv_done_flag_out, irq_req_out, busy_out,
   input wire [9:0] dac_code_out
);
   reg [9:0] len_reg;
   reg [7:0] ref_reg;
   wire mode = converter_control_reg_out[3];
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // busy length and a shadow of the reference, so timing and loads can be judged
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         len_reg <= 10'h000;
         ref_reg <= 8'h00;
      end
      else
      begin
         len_reg <= busy_out ? len_reg + 10'h001 : 10'h000;
         if (load_compare_ref_op_in && mode)
            ref_reg <= {reg_b_in, reg_a_in};
      end
   end
   chk_start_busy: assert property (conv_start_op_in && !busy_out |=> busy_out)
      else $error("start not taken");
   chk_start_clear: assert property (conv_start_op_in && !busy_out && !mode
      |=> dac_code_out == 10'h200) else $error("first trial wrong");
   chk_conv_len: assert property ($fell(busy_out) && !mode |-> conv_done_flag_out
      && len_reg + 2 >= CONV_CYCLES * MCYCLE_DIV && len_reg <= CONV_CYCLES * MCYCLE_DIV
      + MCYCLE_DIV + 2) else $error("conversion length or flag wrong");
   chk_high_read: assert property (read_result_high_op_in && !busy_out && !mode |=>
      data_valid_out && {data_b_out, data_a_out} == $past(dac_code_out[9:2]))
      else $error("high read wrong");
   chk_low_read: assert property (read_result_low_op_in && !busy_out && !mode |=>
      data_a_out == {$past(dac_code_out[1:0]), 2'b00}) else $error("low read wrong");
   chk_skip_clear: assert property (skip_if_done_op_in && conv_done_flag_out
      && !irq_enable_in && !busy_out |=> skip_out && !conv_done_flag_out)
      else $error("skip did not clear flag");
   chk_ref_refuse: assert property ((load_compare_ref_op_in || read_compare_ref_op_in)
      && !mode |=> !data_valid_out) else $error("reference reached in conversion mode");
   chk_cmp_dac: assert property (mode && $past(mode, 2) && !$past(load_compare_ref_op_in)
      |-> dac_code_out == {ref_reg, 2'b00}) else $error("comparator dac code wrong");
   chk_irq_pulse: assert property (irq_req_out |-> irq_enable_in && $past(busy_out)
      && !busy_out) else $error("stray interrupt request");
   cover property (irq_req_out);
   cover property ($fell(busy_out) && mode);
   cover property (skip_out);
endmodule
bind sacc_top sacc_chk #(.MCYCLE_DIV(MCYCLE_DIV), .CONV_CYCLES(CONV_CYCLES)) u_sacc_chk (
   .clk_in(clk_in), .rstn_in(rstn_in), .conv_start_op_in(conv_start_op_in),
   .read_result_high_op_in(read_result_high_op_in), .read_result_low_op_in(read_result_low_op_in),
   .load_compare_ref_op_in(load_compare_ref_op_in), .skip_if_done_op_in(skip_if_done_op_in),
   .read_compare_ref_op_in(read_compare_ref_op_in), .irq_enable_in(irq_enable_in),
   .data_valid_out(data_valid_out), .skip_out(skip_out), .reg_a_in(reg_a_in),
   .reg_b_in(reg_b_in), .data_a_out(data_a_out), .data_b_out(data_b_out),
   .converter_control_reg_out(converter_control_reg_out), .busy_out(busy_out),
   .conv_done_flag_out(conv_done_flag_out), .irq_req_out(irq_req_out),
   .dac_code_out(dac_code_out));

// *** tb/sacc_analog_model.sv ***
`timescale 1ns/1ps
// dac plus comparator; vin is in 1/1024 steps of supply, 11 bits to reach full scale
module sacc_analog_model (
   input wire [9:0] dac_code_in,
   input wire [3:0] input_select_in,
   input wire [10:0] vin_in,
   output wire cmp_ref_below_out
);
   // a deselected input reads as ground, so the comparator never trips
   assign cmp_ref_below_out = (input_select_in != 4'h0) && ({1'b0, dac_code_in} < vin_in);
endmodule

// *** tb/sar_adc_comparator_control_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module sar_adc_comparator_control_test;
   reg clk_in = 0, rstn_in = 0, ien = 0;
   reg start_op = 0, hi_op = 0, lo_op = 0, ldr_op = 0, rdr_op = 0, skip_op = 0, wr_op = 0, ack = 0;
   reg [3:0] reg_a = 4'h0, reg_b = 4'h0;
   reg [10:0] analog_input_voltage = 11'h000;
   reg [10:0] vtab [0:3] = '{11'h000, 11'h2AA, 11'h400, 11'h155};
   reg [9:0] r;
   wire [3:0] data_a, data_b, ctrl, sel;
   wire [9:0] dac;
   wire valid, skip, flag, irq, busy, below;
   int errors = 0, total_checks = 0, n, i;
   sacc_top #(.MCYCLE_DIV(1)) u_sacc_top (.clk_in(clk_in), .rstn_in(rstn_in),
      .conv_start_op_in(start_op), .read_result_high_op_in(hi_op), .read_result_low_op_in(lo_op),
      .load_compare_ref_op_in(ldr_op), .read_compare_ref_op_in(rdr_op), .irq_ack_in(ack),
      .skip_if_done_op_in(skip_op), .write_control_op_in(wr_op), .reg_a_in(reg_a),
      .reg_b_in(reg_b), .irq_enable_in(ien), .cmp_ref_below_in(below), .data_a_out(data_a),
      .data_b_out(data_b), .data_valid_out(valid), .skip_out(skip), .irq_req_out(irq),
      .converter_control_reg_out(ctrl), .conv_done_flag_out(flag), .busy_out(busy),
      .dac_code_out(dac), .input_select_out(sel));
   sacc_analog_model u_sacc_analog_model (.dac_code_in(dac), .input_select_in(sel),
      .vin_in(analog_input_voltage), .cmp_ref_below_out(below));
   initial forever #50 clk_in = ~clk_in;
   // idle edge first, then one instruction strobe for one clock; k picks the instruction
   task op(input [2:0] k, input [3:0] a, input [3:0] b);
   begin
      @(posedge clk_in);
      #1;
      reg_a = a;
      reg_b = b;
      {start_op, hi_op, lo_op, ldr_op, rdr_op, skip_op, wr_op, ack} = 8'h80 >> k;
      @(posedge clk_in);
      #1;
      {start_op, hi_op, lo_op, ldr_op, rdr_op, skip_op, wr_op, ack} = 8'h00;
   end
   endtask
   // start, then count clocks until busy drops; a second start mid-run must be ignored
   task run(input [10:0] v);
   begin
      analog_input_voltage = v;
      op(0, 4'h0, 4'h0);
      `CHK(busy, 1'b1)
      if (!ctrl[3]) `CHK(dac, 10'h200)
      n = 1;
      while (busy === 1'b1 && n < 200)
      begin
         @(posedge clk_in);
         #1;
         n++;
         start_op = (n == 5);
      end
      if (n >= 200)
      begin
         errors++;
         finish_test;
      end
   end
   endtask
   task finish_test;
   begin
      if (errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (3) @(posedge clk_in);
      #1;
      rstn_in = 1;
      `CHK({ctrl, flag, busy}, 6'h00)
      for (i = 0; i < 8; i++)
      begin
         op(6, i[3:0], 4'h0);
         @(posedge clk_in);
         #1;
         `CHK(sel, (4'h1 << {i[2], i[0]}) & {4{i[1] == 1'b0}})
         `CHK(ctrl, i[3:0])
      end
      op(6, 4'h0, 4'h0);
      for (i = 0; i < 4; i++)
      begin
         ien = i[0];
         run(vtab[i]);
         r = (vtab[i] == 11'h000) ? 10'h000 : vtab[i][9:0] - 10'h001;
         if (vtab[i] == 11'h400) r = 10'h3FF;
         `CHK(n >= 61 && n <= 65, 1'b1)
         `CHK({flag, irq}, {1'b1, ien})
         op(5, 4'h0, 4'h0);
         `CHK(skip, ~ien)
         if (ien) op(7, 4'h0, 4'h0);
         `CHK(flag, 1'b0)
         op(1, 4'h0, 4'h0);
         `CHK({valid, data_b, data_a}, {1'b1, r[9:2]})
         op(2, 4'h0, 4'h0);
         `CHK({data_b, data_a}, {r[9:6], r[1:0], 2'b00})
      end
      ien = 0;
      op(4, 4'h0, 4'h0);
      `CHK(valid, 1'b0)
      op(3, 4'hF, 4'hF);
      op(6, 4'h8, 4'h0);
      op(3, 4'h0, 4'h8);
      op(4, 4'h0, 4'h0);
      `CHK({valid, data_b, data_a}, 9'h180)
      `CHK(dac, 10'h200)
      for (i = 0; i < 2; i++)
      begin
         run(i ? 11'h300 : 11'h100);
         `CHK({n >= 7 && n <= 11, flag}, {1'b1, ~i[0]})
         op(5, 4'h0, 4'h0);
         `CHK({skip, flag}, {~i[0], 1'b0})
      end
      op(6, 4'h0, 4'h0);
      op(5, 4'h0, 4'h0);
      `CHK(flag, 1'b0)
      op(6, 4'h8, 4'h0);
      op(4, 4'h0, 4'h0);
      `CHK({data_b, data_a}, 8'h80)
      finish_test;
   end
endmodule
